// [rtl/tsi_defs.svh]
// register offsets, field positions, reset values and codes of the
// connection-memory access block; included by the RTL modules, not by the package
`ifndef TSI_DEFS_SVH
`define TSI_DEFS_SVH

// register indices (A13..A0); byte address is four times the index
`define TSI_IDX_CTRL        14'h0000
`define TSI_IDX_DMS         14'h0001
`define TSI_IDX_BPM         14'h0002
`define TSI_IDX_MEM_BIT     13

// control_reg fields
`define TSI_CR_MS_LSB       0
`define TSI_CR_MBP_BIT      3
`define TSI_CR_BER_BIT      4
`define TSI_CR_FRM_LSB      5
`define TSI_CR_CLK_BIT      7
`define TSI_CR_MASK         16'h00FF
`define TSI_CR_RST          16'h0000

// device_mode_select_reg fields
`define TSI_DMS_BMS_BIT     0
`define TSI_DMS_LG0_LSB     1
`define TSI_DMS_LG1_LSB     3
`define TSI_DMS_LG2_LSB     5
`define TSI_DMS_LG3_LSB     7
`define TSI_DMS_MASK        16'h01FF
`define TSI_DMS_RST         16'h0000

// block_program_reg fields
`define TSI_BPM_BBP_LSB     0
`define TSI_BPM_LBP_LSB     3
`define TSI_BPM_BPE_BIT     6
`define TSI_BPM_MASK        16'h007F
`define TSI_BPM_RST         16'h0000

// memory_select_field codes
`define TSI_MS_BCM          3'h0
`define TSI_MS_LCM          3'h1

// connection memory entry mode codes
`define TSI_MODE_VAR_LOCAL  3'h0
`define TSI_MODE_CON_LOCAL  3'h1
`define TSI_MODE_VAR_BP     3'h2
`define TSI_MODE_CON_BP     3'h3
`define TSI_MODE_MESSAGE    3'h4
`define TSI_MODE_BER        3'h5
`define TSI_MODE_INPUT      3'h6
`define TSI_MODE_HIZ        3'h7

// block fill geometry: eight entries per row, 1024 rows
`define TSI_FILL_LAST_ROW   10'h3FF

`endif

// [rtl/tsi_pkg.sv]
// types shared by the connection-memory access block and its leaves
// includes nothing; tsi_defs.svh is left to the RTL modules
package tsi_pkg;

    typedef enum logic [1:0] {
        HOST_IDLE,
        HOST_READ,
        HOST_HOLD
    } host_state_t;

    typedef struct packed {
        logic [2:0] mode;
        logic [4:0] src_stream;
        logic [7:0] src_chan;
    } cm_entry_t;

    typedef struct packed {
        logic       valid;
        logic       drive;
        logic       message;
        logic       ber;
        logic       from_backplane;
        logic       const_delay;
        logic [2:0] mode;
        logic [7:0] msg_byte;
        logic [4:0] src_stream;
        logic [7:0] src_chan;
    } slot_answer_t;

    typedef struct packed {
        logic       backplane_mode_select_bit;
        logic [1:0] local_group3_mode;
        logic [1:0] local_group2_mode;
        logic [1:0] local_group1_mode;
        logic [1:0] local_group0_mode;
        logic [1:0] local_frame_mode;
        logic       local_clock_mode;
        logic       ber_enable;
    } cfg_t;

    typedef struct packed {
        logic       busy;
        logic       done;
        logic [9:0] row;
    } fill_state_t;

    typedef struct packed {
        host_state_t  host;
        logic         host_sel_bp;
        logic [15:0]  control_reg;
        logic [15:0]  device_mode_select_reg;
        logic [15:0]  block_program_reg;
        logic [31:0]  prdata;
        logic         pready;
        logic         pslverr;
        logic         bp_pend;
        logic         bp_pend_fill;
        logic         lc_pend;
        logic         lc_pend_fill;
        slot_answer_t bp_ans;
        slot_answer_t lc_ans;
    } main_state_t;

endpackage

// [rtl/conn_mem.sv]
// one connection memory: 32 streams x 256 channels of 16-bit entries
// stored as eight lanes so a block fill writes eight entries per clock
`timescale 1ns/10ps
`include "tsi_defs.svh"

module conn_mem (
    input  wire logic        clk_i,
    input  wire logic        en_i,
    input  wire logic        we_i,
    input  wire logic [12:0] addr_i,
    input  wire logic [15:0] wdata_i,
    input  wire logic        fill_i,
    input  wire logic [9:0]  fill_row_i,
    input  wire logic [15:0] fill_data_i,
    output logic      [15:0] rdata_o
);
    logic [15:0] lane_rd [8];
    logic [2:0]  sel_q;

    for (genvar lane = 0; lane < 8; lane++) begin : g_lane
        logic [15:0] cells [1024];
        logic [15:0] rd_q;
        always_ff @(posedge clk_i) begin
            // fill owns the array; callers keep other writes away then
            if (fill_i) begin
                cells[fill_row_i] <= fill_data_i;
            end else if (en_i && we_i && addr_i[2:0] == 3'(lane)) begin
                cells[addr_i[12:3]] <= wdata_i;
            end
            if (en_i) begin
                rd_q <= cells[addr_i[12:3]];
            end
        end
        assign lane_rd[lane] = rd_q;
    end

    always_ff @(posedge clk_i) begin
        if (en_i) begin
            sel_q <= addr_i[2:0];
        end
    end

    assign rdata_o = lane_rd[sel_q];
endmodule

// [rtl/block_filler.sv]
// row sequencer for connection memory block programming
// assumes the caller holds start_i until done_o and then drops it
`timescale 1ns/10ps
`include "tsi_defs.svh"

module block_filler (
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic       start_i,
    output logic            busy_o,
    output logic [9:0]      row_o,
    output logic            done_o
);
    tsi_pkg::fill_state_t st_r;
    tsi_pkg::fill_state_t st_nxt;

    always_comb begin
        st_nxt      = st_r;
        st_nxt.done = 1'b0;
        if (st_r.busy) begin
            // 1024 clocks at 10 MHz, well inside two 125 us frames
            if (st_r.row == `TSI_FILL_LAST_ROW) begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
                st_nxt.row  = 10'h000;
            end else begin
                st_nxt.row = st_r.row + 10'h001;
            end
        end else if (start_i && !st_r.done) begin
            st_nxt.busy = 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign busy_o = st_r.busy;
    assign row_o  = st_r.row;
    assign done_o = st_r.done;
endmodule

// [rtl/tsi_cm_access.sv]
// host access to the switch registers and connection memories, with
// per-slot lookup of backplane and local connection entries
// assumes an APB master with 32-bit data and a switch core that asks
// for one slot per side per clock and takes the answer two clocks later
//
// The APB interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "tsi_defs.svh"

module tsi_cm_access (
    input  wire logic                 CLK_I,
    input  wire logic                 RESETN_I,
    input  wire logic                 PSEL_I,
    input  wire logic                 PENABLE_I,
    input  wire logic                 PWRITE_I,
    input  wire logic [15:0]          PADDR_I,
    input  wire logic [31:0]          PWDATA_I,
    output logic      [31:0]          PRDATA_O,
    output logic                      PREADY_O,
    output logic                      PSLVERR_O,
    input  wire logic                 OUTPUT_DRIVE_ENABLE_PIN_I,
    input  wire logic                 BP_SLOT_REQ_I,
    input  wire logic [12:0]          BP_SLOT_ADDR_I,
    input  wire logic                 LC_SLOT_REQ_I,
    input  wire logic [12:0]          LC_SLOT_ADDR_I,
    output tsi_pkg::slot_answer_t     BP_SLOT_O,
    output tsi_pkg::slot_answer_t     LC_SLOT_O,
    output tsi_pkg::cfg_t             CFG_O
);
    tsi_pkg::main_state_t st_r;
    tsi_pkg::main_state_t st_nxt;

    logic [13:0] idx;
    logic        is_mem;
    logic [2:0]  mem_sel;
    logic        host_bp;
    logic        host_lc;
    logic        bp_free;
    logic        lc_free;
    logic        fill_want;
    logic        fill_busy;
    logic        fill_done;
    logic [9:0]  fill_row;
    logic [15:0] bp_fill_data;
    logic [15:0] lc_fill_data;
    logic        bp_en;
    logic        bp_we;
    logic [12:0] bp_addr;
    logic [15:0] bp_rdata;
    logic        lc_en;
    logic        lc_we;
    logic [12:0] lc_addr;
    logic [15:0] lc_rdata;

    // one entry turned into the per-slot switching decision
    function automatic tsi_pkg::slot_answer_t decode_entry(
        input logic [15:0] raw,
        input logic        output_drive_enable_pin,
        input logic        blocked
    );
        tsi_pkg::cm_entry_t    e;
        tsi_pkg::slot_answer_t a;
        e          = raw;
        a          = '0;
        a.valid    = 1'b1;
        a.mode     = e.mode;
        // source slot for switching, raw byte for message mode
        a.src_stream = e.src_stream;
        a.src_chan   = e.src_chan;
        a.msg_byte   = raw[7:0];
        a.message  = (e.mode == `TSI_MODE_MESSAGE);
        a.ber      = (e.mode == `TSI_MODE_BER);
        a.from_backplane = (e.mode == `TSI_MODE_VAR_BP) ||
                           (e.mode == `TSI_MODE_CON_BP);
        a.const_delay    = (e.mode == `TSI_MODE_CON_LOCAL) ||
                           (e.mode == `TSI_MODE_CON_BP);
        // pin low forces every channel to input pin high hands the
        // choice to the entry where 110 means input
        a.drive = output_drive_enable_pin && !blocked &&
                  (e.mode != `TSI_MODE_INPUT) &&
                  (e.mode != `TSI_MODE_HIZ);
        return a;
    endfunction

    // A13..A0 sit on byte address bits 15..2
    assign idx     = PADDR_I[15:2];
    assign is_mem  = idx[`TSI_IDX_MEM_BIT];
    assign mem_sel = st_r.control_reg[`TSI_CR_MS_LSB +: 3];
    assign host_bp = (mem_sel == `TSI_MS_BCM);
    assign host_lc = (mem_sel == `TSI_MS_LCM);
    // slot lookups and fill beat the host; host waits in wait states
    assign bp_free = !fill_busy && !BP_SLOT_REQ_I;
    assign lc_free = !fill_busy && !LC_SLOT_REQ_I;

    // either fill bit starts the same fill of both memories
    assign fill_want = st_r.control_reg[`TSI_CR_MBP_BIT] ||
                       st_r.block_program_reg[`TSI_BPM_BPE_BIT];
    // pattern goes to bits 15..13, everything else cleared
    assign bp_fill_data =
        {st_r.block_program_reg[`TSI_BPM_BBP_LSB +: 3], 13'h0000};
    assign lc_fill_data =
        {st_r.block_program_reg[`TSI_BPM_LBP_LSB +: 3], 13'h0000};

    always_comb begin
        st_nxt = st_r;
        bp_en   = 1'b0;
        bp_we   = 1'b0;
        bp_addr = BP_SLOT_ADDR_I;
        lc_en   = 1'b0;
        lc_we   = 1'b0;
        lc_addr = LC_SLOT_ADDR_I;

        // slot lookups: address is {stream, channel} per location
        st_nxt.bp_pend      = BP_SLOT_REQ_I;
        st_nxt.bp_pend_fill = fill_busy;
        st_nxt.lc_pend      = LC_SLOT_REQ_I;
        st_nxt.lc_pend_fill = fill_busy;
        if (BP_SLOT_REQ_I && !fill_busy) begin
            bp_en = 1'b1;
        end
        if (LC_SLOT_REQ_I && !fill_busy) begin
            lc_en = 1'b1;
        end

        // a slot asked during a fill gets a valid answer with its driver
        // off, since the entry is in the middle of being rewritten
        if (st_r.bp_pend) begin
            st_nxt.bp_ans = decode_entry(bp_rdata,
                                         OUTPUT_DRIVE_ENABLE_PIN_I,
                                         st_r.bp_pend_fill);
        end else begin
            st_nxt.bp_ans.valid = 1'b0;
        end
        if (st_r.lc_pend) begin
            st_nxt.lc_ans = decode_entry(lc_rdata,
                                         OUTPUT_DRIVE_ENABLE_PIN_I,
                                         st_r.lc_pend_fill);
        end else begin
            st_nxt.lc_ans.valid = 1'b0;
        end

        // fill completion clears both start bits; a host write landing in
        // the same cycle is applied after this and so wins
        if (fill_done) begin
            st_nxt.control_reg[`TSI_CR_MBP_BIT]       = 1'b0;
            st_nxt.block_program_reg[`TSI_BPM_BPE_BIT] = 1'b0;
        end

        unique case (st_r.host)
            tsi_pkg::HOST_IDLE: begin
                if (PSEL_I && PENABLE_I) begin
                    st_nxt.prdata  = 32'h0000_0000;
                    st_nxt.pslverr = 1'b0;
                    if (is_mem) begin
                        if (host_bp || host_lc) begin
                            if ((host_bp && bp_free) ||
                                (host_lc && lc_free)) begin
                                // stream A12..A8, channel A7..A0
                                if (host_bp) begin
                                    bp_en   = 1'b1;
                                    bp_we   = PWRITE_I;
                                    bp_addr = idx[12:0];
                                end else begin
                                    lc_en   = 1'b1;
                                    lc_we   = PWRITE_I;
                                    lc_addr = idx[12:0];
                                end
                                st_nxt.host_sel_bp = host_bp;
                                if (PWRITE_I) begin
                                    st_nxt.pready = 1'b1;
                                    st_nxt.host   = tsi_pkg::HOST_HOLD;
                                end else begin
                                    st_nxt.host   = tsi_pkg::HOST_READ;
                                end
                            end
                        end else begin
                            // data memory is read-only and not held
                            // here: reads give zero, writes error
                            st_nxt.pslverr = PWRITE_I;
                            st_nxt.pready  = 1'b1;
                            st_nxt.host    = tsi_pkg::HOST_HOLD;
                        end
                    end else begin
                        st_nxt.pready = 1'b1;
                        st_nxt.host   = tsi_pkg::HOST_HOLD;
                        // register map on A12..A0
                        case (idx)
                            `TSI_IDX_CTRL: begin
                                if (PWRITE_I) begin
                                    st_nxt.control_reg =
                                        PWDATA_I[15:0] & `TSI_CR_MASK;
                                end else begin
                                    st_nxt.prdata =
                                        {16'h0000, st_r.control_reg};
                                end
                            end
                            `TSI_IDX_DMS: begin
                                if (PWRITE_I) begin
                                    st_nxt.device_mode_select_reg =
                                        PWDATA_I[15:0] & `TSI_DMS_MASK;
                                end else begin
                                    st_nxt.prdata =
                                        {16'h0000,
                                         st_r.device_mode_select_reg};
                                end
                            end
                            `TSI_IDX_BPM: begin
                                if (PWRITE_I) begin
                                    st_nxt.block_program_reg =
                                        PWDATA_I[15:0] & `TSI_BPM_MASK;
                                end else begin
                                    st_nxt.prdata =
                                        {16'h0000,
                                         st_r.block_program_reg};
                                end
                            end
                            default: begin
                                st_nxt.pslverr = 1'b1;
                            end
                        endcase
                    end
                end
            end
            tsi_pkg::HOST_READ: begin
                // entry read one cycle ago now stands at the memory output
                st_nxt.prdata = {16'h0000,
                                 st_r.host_sel_bp ? bp_rdata : lc_rdata};
                st_nxt.pready = 1'b1;
                st_nxt.host   = tsi_pkg::HOST_HOLD;
            end
            // the hold cycle shows each answer and ignores the bus while the master drops psel
            tsi_pkg::HOST_HOLD: begin
                st_nxt.pready  = 1'b0;
                st_nxt.pslverr = 1'b0;
                st_nxt.host    = tsi_pkg::HOST_IDLE;
            end
            default: begin
                // an unused state code returns quietly to idle
                st_nxt.pready  = 1'b0;
                st_nxt.pslverr = 1'b0;
                st_nxt.host    = tsi_pkg::HOST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLK_I) begin
        if (!RESETN_I) begin
            // memory arrays keep their contents; only registers clear
            st_r                        <= '0;
            st_r.host                   <= tsi_pkg::HOST_IDLE;
            st_r.control_reg            <= `TSI_CR_RST;
            st_r.device_mode_select_reg <= `TSI_DMS_RST;
            st_r.block_program_reg      <= `TSI_BPM_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // while the filler runs both arrays take only fill writes; slot
    // answers come back with the driver off, host accesses to either array wait
    block_filler u_filler (
        .clk_i    (CLK_I),
        .resetn_i (RESETN_I),
        .start_i  (fill_want),
        .busy_o   (fill_busy),
        .row_o    (fill_row),
        .done_o   (fill_done)
    );

    // host writes share PWDATA_I; only the selected memory sees we
    conn_mem u_bcm (
        .clk_i       (CLK_I),
        .en_i        (bp_en),
        .we_i        (bp_we),
        .addr_i      (bp_addr),
        .wdata_i     (PWDATA_I[15:0]),
        .fill_i      (fill_busy),
        .fill_row_i  (fill_row),
        .fill_data_i (bp_fill_data),
        .rdata_o     (bp_rdata)
    );

    conn_mem u_lcm (
        .clk_i       (CLK_I),
        .en_i        (lc_en),
        .we_i        (lc_we),
        .addr_i      (lc_addr),
        .wdata_i     (PWDATA_I[15:0]),
        .fill_i      (fill_busy),
        .fill_row_i  (fill_row),
        .fill_data_i (lc_fill_data),
        .rdata_o     (lc_rdata)
    );

    // every output is a bare register, so no bus path reaches a pin
    assign PRDATA_O  = st_r.prdata;
    assign PREADY_O  = st_r.pready;
    assign PSLVERR_O = st_r.pslverr;
    assign BP_SLOT_O = st_r.bp_ans;
    assign LC_SLOT_O = st_r.lc_ans;

    // mode fields straight from the registers
    assign CFG_O.backplane_mode_select_bit =
        st_r.device_mode_select_reg[`TSI_DMS_BMS_BIT];
    assign CFG_O.local_group3_mode =
        st_r.device_mode_select_reg[`TSI_DMS_LG3_LSB +: 2];
    assign CFG_O.local_group2_mode =
        st_r.device_mode_select_reg[`TSI_DMS_LG2_LSB +: 2];
    assign CFG_O.local_group1_mode =
        st_r.device_mode_select_reg[`TSI_DMS_LG1_LSB +: 2];
    assign CFG_O.local_group0_mode =
        st_r.device_mode_select_reg[`TSI_DMS_LG0_LSB +: 2];
    assign CFG_O.local_frame_mode =
        st_r.control_reg[`TSI_CR_FRM_LSB +: 2];
    assign CFG_O.local_clock_mode = st_r.control_reg[`TSI_CR_CLK_BIT];
    assign CFG_O.ber_enable       = st_r.control_reg[`TSI_CR_BER_BIT];
endmodule

// [tb/tsi_cm_access_properties.sv]
// assertions on the ports of the connection-memory access block
// assumes the APB master holds PSEL_I and PADDR_I until PREADY_O
`timescale 1ns/10ps
module tsi_cm_access_chk (
    input wire logic                  CLK_I,
    input wire logic                  RESETN_I,
    input wire logic                  PSEL_I,
    input wire logic [15:0]           PADDR_I,
    input wire logic                  PREADY_O,
    input wire logic                  PSLVERR_O,
    input wire logic                  OUTPUT_DRIVE_ENABLE_PIN_I,
    input wire logic                  BP_SLOT_REQ_I,
    input wire logic                  LC_SLOT_REQ_I,
    input wire tsi_pkg::slot_answer_t BP_SLOT_O,
    input wire tsi_pkg::slot_answer_t LC_SLOT_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESETN_I);
    property p_bad_idx; PREADY_O && PSEL_I && !PADDR_I[15]
        && PADDR_I[14:2] > 13'h0002 |-> PSLVERR_O; endproperty
    a_bad_idx: assert property (p_bad_idx) else $error("no reg error");
    property p_reg_ok; PREADY_O && PSEL_I && PADDR_I[15:2] <= 14'h0002
        |-> !PSLVERR_O; endproperty
    a_reg_ok: assert property (p_reg_ok) else $error("reg error");
    property p_bp_lat; BP_SLOT_REQ_I |-> ##2 BP_SLOT_O.valid; endproperty
    a_bp_lat: assert property (p_bp_lat) else $error("bp late");
    property p_lc_lat; LC_SLOT_REQ_I |-> ##2 LC_SLOT_O.valid; endproperty
    a_lc_lat: assert property (p_lc_lat) else $error("lc late");
    property p_bp_off; BP_SLOT_REQ_I ##1 !OUTPUT_DRIVE_ENABLE_PIN_I
        |=> !BP_SLOT_O.drive; endproperty
    a_bp_off: assert property (p_bp_off) else $error("bp drives");
    property p_bp_in; BP_SLOT_O.valid && BP_SLOT_O.mode == 3'h6
        |-> !BP_SLOT_O.drive; endproperty
    a_bp_in: assert property (p_bp_in) else $error("bp input");
    property p_lc_in; LC_SLOT_O.valid && LC_SLOT_O.mode == 3'h6
        |-> !LC_SLOT_O.drive; endproperty
    a_lc_in: assert property (p_lc_in) else $error("lc input");
    property p_bp_msg; BP_SLOT_O.valid && BP_SLOT_O.mode == 3'h4 |->
        BP_SLOT_O.message && BP_SLOT_O.msg_byte == BP_SLOT_O.src_chan;
    endproperty
    a_bp_msg: assert property (p_bp_msg) else $error("bp msg");
    property p_lc_dec; LC_SLOT_O.valid && !LC_SLOT_O.mode[2] |->
        LC_SLOT_O.from_backplane == LC_SLOT_O.mode[1]
        && LC_SLOT_O.const_delay == LC_SLOT_O.mode[0]; endproperty
    a_lc_dec: assert property (p_lc_dec) else $error("lc decode");
    c_err: cover property (PREADY_O && PSLVERR_O);
    c_msg: cover property (BP_SLOT_O.valid && BP_SLOT_O.message);
    c_drv: cover property (LC_SLOT_O.valid && LC_SLOT_O.drive);
endmodule

bind tsi_cm_access tsi_cm_access_chk u_chk (
    .CLK_I(CLK_I), .RESETN_I(RESETN_I), .PSEL_I(PSEL_I), .PADDR_I(PADDR_I),
    .PREADY_O(PREADY_O), .PSLVERR_O(PSLVERR_O),
    .OUTPUT_DRIVE_ENABLE_PIN_I(OUTPUT_DRIVE_ENABLE_PIN_I),
    .BP_SLOT_REQ_I(BP_SLOT_REQ_I), .LC_SLOT_REQ_I(LC_SLOT_REQ_I),
    .BP_SLOT_O(BP_SLOT_O), .LC_SLOT_O(LC_SLOT_O));

// [tb/slot_core_model.sv]
// switch-core stand-in: one slot lookup per go pulse
// assumes go_i changes just after a rising edge
`timescale 1ns/10ps
module slot_core_model (
    input  wire logic        clk_i,
    input  wire logic        go_i,
    input  wire logic [12:0] addr_i,
    output logic             req_o = 1'b0,
    output logic      [12:0] addr_o = 13'h0000
);
    // idle address toggles so a stale value never passes for a lookup
    always_ff @(posedge clk_i) begin
        req_o <= go_i;
        addr_o <= go_i ? addr_i : ~addr_o;
    end
endmodule

// [tb/testbench.sv]
// self-checking bench for the connection-memory access block
// drives APB itself and slot lookups through two core models
`timescale 1ns/10ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
    $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module testbench;
    logic                  clk = 1'b0, rst_n = 1'b0, output_drive_enable_pin = 1'b0;
    logic                  psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [15:0]           paddr = 16'h0000;
    logic [31:0]           pwdata = 32'h0, prdata;
    logic                  pready, pslverr, bp_req, lc_req;
    logic                  bp_go = 1'b0, lc_go = 1'b0;
    logic [12:0]           go_addr = 13'h0000, bp_addr, lc_addr;
    tsi_pkg::slot_answer_t bp_ans, lc_ans;
    tsi_pkg::cfg_t         cfg;
    int                    bad_count = 0, n_checks = 0;

    always #50 clk = ~clk;
    tsi_cm_access uut (
        .CLK_I(clk), .RESETN_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata),
        .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
        .OUTPUT_DRIVE_ENABLE_PIN_I(output_drive_enable_pin), .BP_SLOT_REQ_I(bp_req),
        .BP_SLOT_ADDR_I(bp_addr), .LC_SLOT_REQ_I(lc_req),
        .LC_SLOT_ADDR_I(lc_addr), .BP_SLOT_O(bp_ans), .LC_SLOT_O(lc_ans),
        .CFG_O(cfg));
    slot_core_model bp_core (.clk_i(clk), .go_i(bp_go), .addr_i(go_addr),
        .req_o(bp_req), .addr_o(bp_addr));
    slot_core_model lc_core (.clk_i(clk), .go_i(lc_go), .addr_i(go_addr),
        .req_o(lc_req), .addr_o(lc_addr));

    task automatic print_verdict;
        if (bad_count == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    function automatic logic [15:0] ma(input int s, input int c);
        return {1'b1, 5'(s), 8'(c), 2'b00};
    endfunction

    task automatic apb(input logic w, input logic [15:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int i;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        for (i = 0; i < 2000; i++) begin
            @(posedge clk);
            if (pready === 1'b1) break;
        end
        if (i == 2000) begin
            bad_count++;
            print_verdict();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        apb(1'b0, 16'h0004, 32'h0, r, e);
        `CHK("mode reset", 32'h0, r)
        apb(1'b1, 16'h0004, 32'hFFFF, r, e);
        apb(1'b1, 16'h0000, 32'hFFF7, r, e);
        apb(1'b0, 16'h0004, 32'h0, r, e);
        `CHK("mode mask", 32'h1FF, r)
        `CHK("cfg", 13'h1FFF, cfg)
        apb(1'b0, 16'h000C, 32'h0, r, e);
        `CHK("idx3 err", 1'b1, e)
        apb(1'b1, ma(2, 9), 32'h5, r, e);
        `CHK("dm write err", 1'b1, e)
        apb(1'b0, ma(2, 9), 32'h0, r, e);
        `CHK("dm read", 32'h0, r)
    endtask

    task automatic look(input int s, input logic [12:0] a,
                        output tsi_pkg::slot_answer_t x);
        int i;
        @(posedge clk);
        go_addr <= a;
        bp_go <= (s == 0);
        lc_go <= (s == 1);
        @(posedge clk);
        bp_go <= 1'b0;
        lc_go <= 1'b0;
        for (i = 0; i < 8; i++) begin
            @(posedge clk);
            x = (s == 1) ? lc_ans : bp_ans;
            if (x.valid === 1'b1) break;
        end
        if (i == 8) begin
            bad_count++;
            print_verdict();
        end
    endtask

    task automatic t_slots;
        logic [31:0]           r;
        logic                  e;
        tsi_pkg::slot_answer_t x;
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, 16'h0000, 32'(s), r, e);
            for (int m = 0; m < 8; m++)
                apb(1'b1, ma(30 + s, m), 32'({3'(m), 5'(m + s),
                    8'(192 + m)}), r, e);
            apb(1'b0, ma(30 + s, 3), 32'h0, r, e);
            `CHK("cm entry", 32'({3'h3, 5'(3 + s), 8'hC3}), r)
        end
        for (int o = 0; o < 2; o++) begin
            output_drive_enable_pin <= o[0];
            for (int s = 0; s < 2; s++) for (int m = 0; m < 8; m++) begin
                look(s, {5'(30 + s), 8'(m)}, x);
                `CHK("slot", {1'b1, o == 1 && m < 6, m == 4, m == 5,
                    m == 2 || m == 3, m == 1 || m == 3, 3'(m), 8'(192 + m),
                    5'(m + s), 8'(192 + m)}, x)
            end
        end
    endtask

    task automatic t_fill;
        logic [31:0] r;
        logic        e;
        apb(1'b1, 16'h0000, 32'h0, r, e);
        apb(1'b1, 16'h0008, 32'h55, r, e);
        apb(1'b0, ma(31, 255), 32'h0, r, e);
        `CHK("bp fill", 32'hA000, r)
        apb(1'b0, 16'h0008, 32'h0, r, e);
        `CHK("enable clear", 32'h15, r)
        apb(1'b1, 16'h0000, 32'h1, r, e);
        apb(1'b0, ma(0, 0), 32'h0, r, e);
        `CHK("lc fill", 32'h4000, r)
        apb(1'b1, 16'h0008, 32'h1B, r, e);
        apb(1'b1, 16'h0000, 32'h8, r, e);
        apb(1'b0, ma(7, 9), 32'h0, r, e);
        `CHK("ctrl fill", 32'h6000, r)
        apb(1'b0, 16'h0000, 32'h0, r, e);
        `CHK("fill bit clear", 32'h0, r)
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_slots();
        t_fill();
        print_verdict();
    end
endmodule
